/* File: design/timer_control_status.sv */
// Timer channel: control/status register, overflow flag, clock select, pin GPIO and reload control
// What this block does
// R1: Counter overflow sets overflow_flag at bit 20.
// R2: Writing one clears overflow_flag; writing zero leaves it.
// R3: Servicing the overflow interrupt clears overflow_flag.
// R4: Reset, software reset, stop, or enable cleared clear overflow_flag.
// R5: With select clear, count from clock/2 or the external pin.
// R6: With select set, prescaler output clocks the counter in every mode.
// R7: Software changes prescaler_clock_select only while disabled.
// R8: Two-bit source field picks prescaler input, including other channels' pins.
// R9: GPIO output drives pin from data_out, inverted when pin_invert set.
// R10: Outside GPIO mode data_out writes do not reach the pin.
// R11: pin_data_in shows pin level, inverted when pin_invert set.
// R12: GPIO only with mode zero; direction bit 11 chooses output or input.
// R13: Timer and watchdog modes load the load value on first clock after enable.
// R14: With reload_mode set, timer/watchdog counter reloads on reaching compare.
// R15: PWM mode 7 reloads on every overflow.
// R16: Measurement modes 4-5 reload on each rising input edge with reload and enable.
// R17: With reload_mode clear the counter runs freely in every mode but PWM mode 7, which reloads on every overflow.
// R18: pin_invert sets polarity of input signal and output pulse.
// R19: pin_invert does not affect the pin feeding the prescaler.
// R20: Software changes pin_invert only while disabled or in GPIO mode.
// R21: Software writes zero to reserved bits 19-16, 14 and 10.
// R22: Four-bit mode field selects source, pin role and mode; zero is GPIO timer.
// R23: All implemented control bits reset to zero: GPIO input, no inversion.
`timescale 1ns/10ps
`default_nettype none
module timer_control_status (
   // Clock, reset and core events
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic soft_reset,
   input wire logic stop_request,
   input wire logic overflow_int_ack,
   // Timer pin and the pins of the other channels
   input wire logic timer_io_pin_in,
   input wire logic other_pin_a,
   input wire logic other_pin_b,
   output timer_csr_pkg::pin_drive_t timer_io_pin,
   output logic overflow_event,
   output logic compare_event,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata
);
   import timer_csr_pkg::*;

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   function automatic logic mode_between(input logic [3:0] m, input logic [3:0] lo, input logic [3:0] hi);
      return m >= lo && m <= hi;
   endfunction

   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
      return a == target;
   endfunction

   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   csr_t csr;
   logic [23:0] load_value_register;
   logic [23:0] compare_value_register;
   logic [23:0] count;
   logic [23:0] prescaler_load_register;
   logic [20:0] presc_count;
   logic wr_pending;
   logic [7:0] wr_addr;
   logic pin_sync;
   logic pin_prev;
   logic presc_pin_prev;
   logic div2;
   logic started;

   // -------------------------------------------------------------
   // Bus slave
   // -------------------------------------------------------------
   // Only whole-word NONSEQ transfers are taken
   wire take = hsel && hready && htrans == htrans_nonseq && hsize == hsize_word;

   // Writes land at the end of the data phase, when hwdata stands
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_pending <= 1'b0;
      end else begin
         wr_pending <= take && hwrite;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_addr <= 8'h00;
      end else if (take) begin
         wr_addr <= haddr[7:0];
      end
   end

   // -------------------------------------------------------------
   // Write strobes
   // -------------------------------------------------------------
   wire wr_csr = wr_pending && addr_hit(wr_addr, csr_addr);
   wire wr_load = wr_pending && addr_hit(wr_addr, load_addr);
   wire wr_cmp = wr_pending && addr_hit(wr_addr, compare_addr);
   wire wr_presc = wr_pending && addr_hit(wr_addr, prescale_addr);

   // -------------------------------------------------------------
   // Bus answer
   // -------------------------------------------------------------
   // The slave never stalls and never signals an error
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // -------------------------------------------------------------
   // Mode decode
   // -------------------------------------------------------------
   wire [3:0] mode = csr.mode_select_field;
   wire gpio_mode = mode == mode_gpio; // see R12 see R22
   wire timer_mode = mode_between(mode, mode_gpio, mode_timer_last);
   wire wdog_mode = mode_between(mode, mode_wdog_first, mode_wdog_last);
   wire meas_mode = mode_between(mode, mode_meas_first, mode_meas_last);
   wire pwm_mode = mode == mode_pwm;
   // The event counter mode takes its clock from the pin
   wire ext_clock = mode == mode_timer_last;

   // -------------------------------------------------------------
   // Pin input
   // -------------------------------------------------------------
   wire pin_level = pin_sync ^ csr.pin_invert; // see R11 see R18
   wire pin_rise = pin_level && !(pin_prev ^ csr.pin_invert);

   // One sampling stage: the pin is taken as synchronous
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin_sync <= 1'b0;
         pin_prev <= 1'b0;
         presc_pin_prev <= 1'b0;
      end else begin
         pin_sync <= timer_io_pin_in;
         pin_prev <= pin_sync;
         presc_pin_prev <= presc_pin;
      end
   end

   // -------------------------------------------------------------
   // Clock selection
   // -------------------------------------------------------------
   // The prescaler sees the raw pin level: inversion does not apply there
   wire [1:0] presc_src = prescaler_load_register[presc_src_lsb +: 2];
   wire presc_pin = (presc_src == src_own_pin) ? pin_sync : // see R19
                    (presc_src == src_other_pin_a) ? other_pin_a :
                    (presc_src == src_other_pin_b) ? other_pin_b : 1'b0; // see R8
   wire presc_in_tick = (presc_src == src_clk_div2) ? div2 : (presc_pin && !presc_pin_prev); // see R8
   wire presc_wrap = presc_in_tick && presc_count == 21'h00_0000;
   wire presc_tick = csr.timer_enable_bit && presc_wrap;
   wire own_tick = ext_clock ? pin_rise : div2; // see R5
   wire tick = csr.timer_enable_bit && (csr.prescaler_clock_select ? presc_tick : own_tick); // see R6
   wire at_max = count == 24'hFF_FFFF;
   wire ovf = tick && at_max; // see R1
   wire hit = tick && count == compare_value_register;
   wire clear_flag = soft_reset || stop_request || overflow_int_ack || !csr.timer_enable_bit; // see R3 see R4

   // Internal clock divided by two
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         div2 <= 1'b0;
      end else begin
         div2 <= !div2;
      end
   end

   // -------------------------------------------------------------
   // Pin output
   // -------------------------------------------------------------
   // see R9 see R10 see R12
   assign timer_io_pin.pin_oe = gpio_mode && csr.dir_out;
   assign timer_io_pin.pin_o = csr.data_out ^ csr.pin_invert;

   // -------------------------------------------------------------
   // Control/status register
   // -------------------------------------------------------------
   csr_t next_csr;
   always_comb begin
      next_csr = csr;
      if (wr_csr) begin
         next_csr.timer_enable_bit = hwdata[enable_pos];
         next_csr.mode_select_field = hwdata[mode_lsb +: 4];
         next_csr.pin_invert = hwdata[invert_pos];
         next_csr.reload_mode = hwdata[reload_pos];
         next_csr.dir_out = hwdata[dir_pos];
         next_csr.data_out = hwdata[data_out_pos];
         next_csr.prescaler_clock_select = hwdata[presc_sel_pos];
         if (hwdata[overflow_pos]) begin
            next_csr.overflow_flag = 1'b0; // see R2
         end
      end
      if (clear_flag || !next_csr.timer_enable_bit) begin
         next_csr.overflow_flag = 1'b0; // see R3 see R4
      end
      // A wrap wins over any clear in the same cycle except soft_reset, which restores the reset value
      if (ovf) begin
         next_csr.overflow_flag = 1'b1; // see R1
      end
      if (soft_reset) begin
         next_csr = csr_t'(csr_reset[$bits(csr_t)-1:0]);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         csr <= csr_t'(csr_reset[$bits(csr_t)-1:0]); // see R23
      end else begin
         csr <= next_csr;
      end
   end

   // -------------------------------------------------------------
   // Reload control
   // -------------------------------------------------------------
   wire count_mode = timer_mode || wdog_mode;
   wire reload_first = tick && !started && count_mode; // see R13
   wire reload_cmp = hit && csr.reload_mode && count_mode; // see R14
   wire reload_pwm = ovf && pwm_mode; // see R15
   wire reload_meas = meas_mode && csr.reload_mode && csr.timer_enable_bit && pin_rise; // see R16
   wire do_load = reload_first || reload_cmp || reload_pwm || reload_meas;

   // Remembers that the first tick after enable has loaded the counter
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         started <= 1'b0;
      end else begin
         started <= csr.timer_enable_bit && (started || tick);
      end
   end

   // -------------------------------------------------------------
   // Counter
   // -------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         count <= word_reset;
      end else if (do_load) begin
         count <= load_value_register;
      end else if (tick) begin
         count <= count + 24'h00_0001; // see R17
      end
   end

   // -------------------------------------------------------------
   // Load, compare and prescaler load registers
   // -------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         load_value_register <= word_reset;
         compare_value_register <= word_reset;
         prescaler_load_register <= word_reset;
      end else begin
         if (wr_load) begin
            load_value_register <= hwdata[23:0];
         end
         if (wr_cmp) begin
            compare_value_register <= hwdata[23:0];
         end
         if (wr_presc) begin
            prescaler_load_register <= hwdata[23:0];
         end
      end
   end

   // -------------------------------------------------------------
   // Prescaler
   // -------------------------------------------------------------
   // Held at its preload while disabled so the first period after enable is full
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         presc_count <= 21'h00_0000;
      end else if (!csr.timer_enable_bit || presc_wrap) begin
         presc_count <= prescaler_load_register[20:0];
      end else if (presc_in_tick) begin
         presc_count <= presc_count - 21'h00_0001;
      end
   end

   // -------------------------------------------------------------
   // Event outputs
   // -------------------------------------------------------------
   assign overflow_event = ovf;
   assign compare_event = hit;

   // -------------------------------------------------------------
   // Read data
   // -------------------------------------------------------------
   logic [23:0] csr_view;
   always_comb begin
      csr_view = 24'h00_0000; // see R21
      csr_view[enable_pos] = csr.timer_enable_bit;
      csr_view[mode_lsb +: 4] = csr.mode_select_field;
      csr_view[invert_pos] = csr.pin_invert;
      csr_view[reload_pos] = csr.reload_mode;
      csr_view[dir_pos] = csr.dir_out;
      csr_view[data_in_pos] = pin_level; // see R11
      csr_view[data_out_pos] = csr.data_out;
      csr_view[presc_sel_pos] = csr.prescaler_clock_select;
      csr_view[overflow_pos] = csr.overflow_flag;
   end

   // Read decode uses the address phase; unmapped words read zero
   logic [23:0] rd_word;
   always_comb begin
      rd_word = 24'h00_0000;
      if (addr_hit(haddr[7:0], csr_addr)) begin
         rd_word = csr_view;
      end else if (addr_hit(haddr[7:0], load_addr)) begin
         rd_word = load_value_register;
      end else if (addr_hit(haddr[7:0], compare_addr)) begin
         rd_word = compare_value_register;
      end else if (addr_hit(haddr[7:0], count_addr)) begin
         rd_word = count;
      end else if (addr_hit(haddr[7:0], prescale_addr)) begin
         rd_word = prescaler_load_register;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hrdata <= 32'h0000_0000;
      end else if (take && !hwrite) begin
         hrdata <= {8'h00, rd_word};
      end
   end
endmodule // timer_control_status
`default_nettype wire

/* File: design/timer_csr_pkg.sv */
// Package: register map, field positions, reset values and modes of the timer control/status block
package timer_csr_pkg;
   // Register byte addresses
   localparam logic [7:0] csr_addr = 8'h00;
   localparam logic [7:0] load_addr = 8'h04;
   localparam logic [7:0] compare_addr = 8'h08;
   localparam logic [7:0] count_addr = 8'h0C;
   localparam logic [7:0] prescale_addr = 8'h10;
   // Control/status field positions
   localparam int enable_pos = 0;
   localparam int mode_lsb = 4;
   localparam int invert_pos = 8;
   localparam int reload_pos = 9;
   localparam int dir_pos = 11;
   localparam int data_in_pos = 12;
   localparam int data_out_pos = 13;
   localparam int presc_sel_pos = 15;
   localparam int overflow_pos = 20;
   // Prescaler load register field positions
   localparam int presc_src_lsb = 21;
   // Reset values
   localparam logic [23:0] csr_reset = 24'h00_0000;
   localparam logic [23:0] word_reset = 24'h00_0000;
   // Modes of the mode_select_field
   localparam logic [3:0] mode_gpio = 4'h0;
   localparam logic [3:0] mode_timer_last = 4'h3;
   localparam logic [3:0] mode_meas_first = 4'h4;
   localparam logic [3:0] mode_meas_last = 4'h5;
   localparam logic [3:0] mode_pwm = 4'h7;
   localparam logic [3:0] mode_wdog_first = 4'h9;
   localparam logic [3:0] mode_wdog_last = 4'hA;
   // Prescaler sources
   localparam logic [1:0] src_clk_div2 = 2'h0;
   localparam logic [1:0] src_own_pin = 2'h1;
   localparam logic [1:0] src_other_pin_a = 2'h2;
   localparam logic [1:0] src_other_pin_b = 2'h3;
   // AHB encodings
   localparam logic [1:0] htrans_nonseq = 2'b10;
   localparam logic [2:0] hsize_word = 3'b010;

   typedef struct packed {
      logic overflow_flag;
      logic prescaler_clock_select;
      logic data_out;
      logic dir_out;
      logic reload_mode;
      logic pin_invert;
      logic [3:0] mode_select_field;
      logic timer_enable_bit;
   } csr_t;

   typedef struct packed {
      logic pin_o;
      logic pin_oe;
   } pin_drive_t;
endpackage

/* File: verification/pin_partner.sv */
// Partner model: external circuit on the timer pin, resolving the wire level
`timescale 1ns/10ps
`default_nettype none
module pin_partner (
   input wire timer_csr_pkg::pin_drive_t drive,
   input wire logic ext_level,
   output logic pin_level
);
   // External side releases the pin while the block drives it
   assign pin_level = drive.pin_oe ? drive.pin_o : ext_level;
endmodule // pin_partner
`default_nettype wire

/* File: verification/timer_control_status_checker.sv */
// Checker: concurrent assertions on the ports of the timer control/status block
`timescale 1ns/10ps
`default_nettype none
module timer_csr_checker
   import timer_csr_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic soft_reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic overflow_event,
   input wire logic compare_event,
   input wire timer_csr_pkg::pin_drive_t timer_io_pin
);
   // Shadow of the writable control bits, tracked from bus writes
   logic [15:0] shadow;
   logic wr_q;
   logic rd_q;
   wire take = hsel && hready && htrans == htrans_nonseq && hsize == hsize_word && haddr == {24'h00_0000, csr_addr};
   always_ff @(posedge clk) begin
      if (sys_rst || soft_reset) begin
         shadow <= 16'h0000;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
      end else begin
         if (wr_q) shadow <= hwdata[15:0] & 16'hABF1;
         wr_q <= take && hwrite;
         rd_q <= take && !hwrite;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not zero-wait OKAY");
   gpio_dir_a: assert property (timer_io_pin.pin_oe == (shadow[7:4] == mode_gpio && shadow[dir_pos]))
      else $error("pin enable does not follow mode and direction");
   pin_level_a: assert property (timer_io_pin.pin_o == (shadow[data_out_pos] ^ shadow[invert_pos]))
      else $error("pin output not data out with inversion");
   rst_quiet_a: assert property (disable iff (1'b0) $past(sys_rst) && !sys_rst |->
      !timer_io_pin.pin_oe && !timer_io_pin.pin_o && hrdata == 32'h0000_0000) else $error("outputs not zero after reset");
   csr_read_a: assert property (rd_q |-> (hrdata[15:0] & 16'hABF1) == shadow)
      else $error("control read does not match writes");
   rsvd_zero_a: assert property (rd_q |-> (hrdata & 32'hFFCF_4400) == 32'h0000_0000)
      else $error("reserved control bits read nonzero");
   idle_quiet_a: assert property (!shadow[enable_pos] |-> !overflow_event && !compare_event)
      else $error("counter event while disabled");
   ovf_pulse_a: assert property (overflow_event |=> !overflow_event) else $error("overflow event longer than a cycle");
   cover property (rd_q);
   cover property ($rose(timer_io_pin.pin_oe));
   cover property (overflow_event);
   cover property (compare_event);
endmodule // timer_csr_checker
bind timer_control_status timer_csr_checker i_timer_csr_checker (.clk, .sys_rst, .soft_reset, .hsel, .haddr, .htrans,
   .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .overflow_event, .compare_event, .timer_io_pin);
`default_nettype wire

/* File: verification/tb_timer_control_status.sv */
// Testbench: timer control/status block over AHB-Lite with a pin partner
`timescale 1ns/10ps
`default_nettype none
module tb_timer_control_status;
   import timer_csr_pkg::*;
   typedef struct packed {logic [15:0] csr; logic ext; logic oe; logic di;} row_t;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic soft_reset = 1'b0;
   logic stop_request = 1'b0;
   logic overflow_int_ack = 1'b0;
   logic ext_level = 1'b0;
   logic other_pin_a = 1'b0;
   logic other_pin_b = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h0;
   logic [31:0] hrdata;
   logic [31:0] q;
   logic pin_level;
   logic hreadyout;
   logic hresp;
   logic overflow_event;
   logic compare_event;
   pin_drive_t timer_io_pin;
   int error_cnt = 0;
   int tests_run = 0;
   int cyc = 0;
   int ovf;
   int cmp;
   row_t rows [8] = '{'{16'h2800, 1'b0, 1'b1, 1'b1}, '{16'h2900, 1'b0, 1'b1, 1'b1}, '{16'h0900, 1'b1, 1'b1, 1'b0},
      '{16'h2000, 1'b1, 1'b0, 1'b1}, '{16'h0100, 1'b1, 1'b0, 1'b0}, '{16'h0100, 1'b0, 1'b0, 1'b1},
      '{16'h2810, 1'b1, 1'b0, 1'b1}, '{16'h2950, 1'b0, 1'b0, 1'b1}};
   always #25 clk = ~clk;
   timer_control_status i_timer_control_status (.clk, .sys_rst, .soft_reset, .stop_request, .overflow_int_ack,
      .timer_io_pin_in(pin_level), .other_pin_a, .other_pin_b, .timer_io_pin, .overflow_event, .compare_event,
      .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata);
   pin_partner i_pin_partner (.drive(timer_io_pin), .ext_level, .pin_level);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= htrans_nonseq;
      hwrite <= wr;
      hsize <= hsize_word;
      @(posedge clk iff hreadyout === 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk iff hreadyout === 1'b1);
      q = hrdata;
   endtask
   task automatic complete_run();
      $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         error_cnt++;
         complete_run();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      bus(1'b0, csr_addr, 32'h0000_0000);
      chk(q, {8'h00, csr_reset});
      chk({30'h0000_0000, timer_io_pin}, 32'h0000_0000);
      $display("reset test done");
      foreach (rows[i]) begin
         ext_level <= rows[i].ext;
         bus(1'b1, csr_addr, {16'h0000, rows[i].csr});
         repeat (3) @(posedge clk);
         chk({31'h0000_0000, timer_io_pin.pin_oe}, {31'h0000_0000, rows[i].oe});
         bus(1'b0, csr_addr, 32'h0000_0000);
         chk(q, {16'h0000, rows[i].csr | {3'h0, rows[i].di, 12'h000}});
      end
      bus(1'b1, 8'h20, 32'hFFFF_FFFF);
      bus(1'b0, 8'h20, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      $display("pin table and unmapped test done");
      for (int k = 0; k < 6; k++) begin
         bus(1'b1, csr_addr, 32'h0000_0000);
         bus(1'b1, load_addr, 32'h00FF_FFF0);
         bus(1'b1, csr_addr, 32'h0000_0001);
         @(posedge clk iff overflow_event === 1'b1);
         bus(1'b0, csr_addr, 32'h0000_0000);
         chk({31'h0000_0000, q[overflow_pos]}, 32'h0000_0001);
         if (k == 0) bus(1'b1, csr_addr, 32'h0000_0001);
         if (k == 1) bus(1'b1, csr_addr, 32'h0010_0001);
         if (k == 5) bus(1'b1, csr_addr, 32'h0000_0000);
         if (k inside {[2:4]}) begin
            @(posedge clk);
            {soft_reset, stop_request, overflow_int_ack} <= 3'h1 << (k - 2);
            @(posedge clk);
            {soft_reset, stop_request, overflow_int_ack} <= 3'h0;
         end
         bus(1'b0, csr_addr, 32'h0000_0000);
         chk({31'h0000_0000, q[overflow_pos]}, {31'h0000_0000, k == 0});
      end
      $display("overflow flag test done");
      for (int r = 0; r < 2; r++) begin
         bus(1'b1, csr_addr, 32'h0000_0000);
         bus(1'b1, compare_addr, 32'h00FF_FFF4);
         bus(1'b1, csr_addr, r ? 32'h0000_0001 : 32'h0000_0201);
         ovf = 0;
         cmp = 0;
         repeat (200) begin
            @(posedge clk);
            ovf += overflow_event;
            cmp += compare_event;
         end
         chk({31'h0000_0000, r ? (ovf == 1 && cmp == 1) : (ovf == 0 && cmp >= 10)}, 32'h0000_0001);
      end
      $display("reload test done");
      bus(1'b1, csr_addr, 32'h0000_0000);
      bus(1'b1, load_addr, 32'h0000_0000);
      bus(1'b1, csr_addr, 32'h0000_0031);
      repeat (40) @(posedge clk) ext_level <= !ext_level;
      repeat (3) @(posedge clk);
      bus(1'b0, count_addr, 32'h0000_0000);
      chk(q, 32'h0000_0013);
      bus(1'b1, csr_addr, 32'h0000_0000);
      bus(1'b1, load_addr, 32'h00FF_FFF0);
      bus(1'b1, prescale_addr, 32'h0000_0001);
      bus(1'b1, csr_addr, 32'h0000_8031);
      ovf = 0;
      repeat (50) @(posedge clk) ovf += overflow_event;
      chk(ovf, 32'h0000_0000);
      repeat (50) @(posedge clk) ovf += overflow_event;
      chk(ovf, 32'h0000_0001);
      $display("counter source test done");
      complete_run();
   end
endmodule // tb_timer_control_status
`default_nettype wire
